// ### tb.sv
// Self-checking bench for the wake and sleep power sequencer
`timescale 1ns/1ps
module tb;
  import wsps_pkg::*;
  // Drive, observation and bookkeeping
  logic core_clk, sys_rst, psel, penable, pwrite, pready, pslverr, rx_fifo_has_packet;
  logic [7:0] paddr, wake_event_in;
  logic [31:0] pwdata, prdata;
  logic pin_level, pin_out, pin_oe, phy_power_on, rx_desc_fetch, rx_dma_drain, rx_running;
  int error_cnt, n_tests, fetch_cnt, drain_cnt;
  wsps_top dut (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wake_event_in(wake_event_in), .rx_fifo_has_packet(rx_fifo_has_packet),
    .wake_request_n_pin_in(pin_level), .wake_request_n_pin_out(pin_out),
    .wake_request_n_pin_oe(pin_oe), .phy_power_on(phy_power_on), .rx_desc_fetch(rx_desc_fetch),
    .rx_dma_drain(rx_dma_drain), .rx_running(rx_running));
  wsps_pin_model u_pin (.drive_oe(pin_oe), .drive_val(pin_out), .pin_level(pin_level));
  // 250 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // Count one-cycle receive pulses
  always @(posedge core_clk) begin
    if (rx_desc_fetch === 1'b1) fetch_cnt++;
    if (rx_dma_drain === 1'b1) drain_cnt++;
  end
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      $display("FAIL %s expected %h seen %h", n, x, g);
      error_cnt++;
    end
  endtask
  // One APB transfer; held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk("pslverr", {31'h0, ee}, {31'h0, e});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk("prdata", x, r & m);
  endtask
  task automatic do_reset;
    sys_rst <= 1'b1;
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
  endtask
  // Registers locked after reset until config restored
  task automatic t_lock;
    rd(OFF_POWER_STATE_CONTROL_STATUS, 32'hffffffff, 32'h0);
    wr(OFF_RECEIVE_DESCRIPTOR_POINTER, 32'h1000, 1'b1);
    wr(8'h1c, 32'h0, 1'b1);
    wr(OFF_CONFIG_RESTORE, 32'h3, 1'b0);
    wr(OFF_RECEIVE_DESCRIPTOR_POINTER, 32'h1000, 1'b0);
    rd(OFF_RECEIVE_DESCRIPTOR_POINTER, 32'hffffffff, 32'h1000);
    $display("TEST lock done");
  endtask
  // Armed D3hot, wake event, exit sequence
  task automatic t_wake;
    int i;
    rx_fifo_has_packet <= 1'b1;
    wr(OFF_WAKE_CONTROL_STATUS, 32'h1, 1'b0);
    wr(OFF_POWER_STATE_CONTROL_STATUS, 32'h0103, 1'b0);
    @(negedge core_clk);
    chk("phy_power_on", 1, phy_power_on);
    @(posedge core_clk);
    wake_event_in <= 8'h01;
    for (i = 0; i < 20 && pin_level !== 1'b0; i++) @(posedge core_clk);
    chk("pin", 0, pin_level);
    wake_event_in <= 8'h00;
    repeat (8) @(posedge core_clk);
    chk("pin", 0, pin_level);
    rd(OFF_SEQ_STATUS, 32'hc0, 32'h40);
    rd(OFF_POWER_STATE_CONTROL_STATUS, 32'h8000, 32'h8000);
    wr(OFF_POWER_STATE_CONTROL_STATUS, 32'h0, 1'b0);
    @(negedge core_clk);
    chk("pin", 1, pin_level);
    wr(OFF_RECEIVE_DESCRIPTOR_POINTER, 32'h0, 1'b1);
    rd(OFF_POWER_STATE_CONTROL_STATUS, 32'hffff, 32'h8000);
    wr(OFF_CONFIG_RESTORE, 32'h3, 1'b0);
    rd(OFF_WAKE_CONTROL_STATUS, 32'h00ff00ff, 32'h00010001);
    wr(OFF_CLOCKRUN_CONTROL_STATUS, 32'h8000, 1'b0);
    rd(OFF_POWER_STATE_CONTROL_STATUS, 32'hffff, 32'h0);
    wr(OFF_WAKE_CONTROL_STATUS, 32'h0, 1'b0);
    $display("TEST wake done");
  endtask
  // Receiver restart fetches once and drains the held packet only when one is expected
  task automatic t_rx(input logic [31:0] ptr, input int drains);
    wr(OFF_COMMAND_REGISTER, 32'h8, 1'b0);
    @(negedge core_clk);
    chk("rx_running", 0, rx_running);
    wr(OFF_RECEIVE_DESCRIPTOR_POINTER, ptr, 1'b0);
    fetch_cnt = 0;
    drain_cnt = 0;
    wr(OFF_COMMAND_REGISTER, 32'h4, 1'b0);
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    chk("fetch", 1, fetch_cnt);
    chk("drain", drains, drain_cnt);
    chk("rx_running", 1, rx_running);
    $display("TEST rx done");
  endtask
  // Sleep in D3hot, then D3cold exit by reset
  task automatic t_sleep;
    wr(OFF_POWER_STATE_CONTROL_STATUS, 32'h0003, 1'b0);
    @(negedge core_clk);
    chk("phy_power_on", 0, phy_power_on);
    @(posedge core_clk);
    wake_event_in <= 8'hff;
    repeat (10) @(posedge core_clk);
    chk("pin", 1, pin_level);
    wake_event_in <= 8'h00;
    do_reset();
    @(negedge core_clk);
    chk("phy_power_on", 1, phy_power_on);
    rd(OFF_POWER_STATE_CONTROL_STATUS, 32'hffffffff, 32'h0);
    wr(OFF_COMMAND_REGISTER, 32'h4, 1'b1);
    wr(OFF_POWER_STATE_CONTROL_STATUS, 32'h0, 1'b0);
    wr(OFF_CONFIG_RESTORE, 32'h3, 1'b0);
    $display("TEST sleep done");
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Hang guard, far beyond the roughly 150 cycles of the run
  initial begin
    #20000;
    error_cnt++;
    end_sim();
  end
  // Main sequence
  initial begin
    {sys_rst, psel, penable, pwrite, rx_fifo_has_packet} = 5'h10;
    paddr = 8'h00;
    pwdata = 32'h0;
    wake_event_in = 8'h00;
    error_cnt = 0;
    n_tests = 0;
    do_reset();
    t_lock();
    t_wake();
    t_rx(32'h2000, 1);
    t_rx(32'h0, 0);
    t_sleep();
    t_rx(32'h3000, 0);
    end_sim();
  end
endmodule // tb

// ### wsps_checker.sv
// Port-level assertions for the wake and sleep power sequencer
`timescale 1ns/1ps
module wsps_checker
  import wsps_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // APB slave side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Wake pin and receive path
  input wire logic wake_request_n_pin_out,
  input wire logic wake_request_n_pin_oe,
  input wire logic rx_desc_fetch,
  input wire logic rx_dma_drain
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Accepted writes, refused ones excluded since they change nothing
  logic acc, wr00, wr_clr, wr_rxe;
  assign acc = psel && penable;
  assign wr00 = acc && pwrite && !pslverr && paddr == OFF_POWER_STATE_CONTROL_STATUS;
  assign wr_clr = wr00 || (acc && pwrite && !pslverr && paddr == OFF_CLOCKRUN_CONTROL_STATUS);
  assign wr_rxe = acc && pwrite && !pslverr && paddr == OFF_COMMAND_REGISTER
    && pwdata[RX_ENABLE_BIT];
  a_ready_zero_wait: assert property (pready == acc) else $error("pready not zero wait");
  a_err_unmapped: assert property (acc && paddr > OFF_SEQ_STATUS |-> pslverr)
    else $error("unmapped access not refused");
  a_pin_low_only: assert property (wake_request_n_pin_out == 1'b0)
    else $error("wake pin driven high");
  a_release_on_clear: assert property (wr00 && !pwdata[WAKE_ENABLE_BIT]
    |=> !wake_request_n_pin_oe) else $error("wake pin kept after enable cleared");
  a_status_holds: assert property ($fell(wake_request_n_pin_oe) |-> $past(wr_clr))
    else $error("wake pin released without clear");
  a_fetch_pulse: assert property (rx_desc_fetch |=> !rx_desc_fetch)
    else $error("fetch longer than one cycle");
  a_fetch_cause: assert property (rx_desc_fetch |-> $past(wr_rxe) || $past(wr_rxe, 2))
    else $error("fetch without receive enable");
  a_drain_after: assert property (rx_dma_drain |-> $past(rx_desc_fetch))
    else $error("drain before descriptor fetch");
endmodule // wsps_checker

bind wsps_top wsps_checker u_chk (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .wake_request_n_pin_out(wake_request_n_pin_out),
  .wake_request_n_pin_oe(wake_request_n_pin_oe), .rx_desc_fetch(rx_desc_fetch),
  .rx_dma_drain(rx_dma_drain));

// ### wsps_pin_model.sv
// System side of the open-drain wake line with its pull-up
`timescale 1ns/1ps
module wsps_pin_model (
  // Device drive
  input wire logic drive_oe,
  input wire logic drive_val,
  // Resolved line level
  output logic pin_level
);
  // Pull-up wins when released, so a stale low can never linger
  assign pin_level = drive_oe ? drive_val : 1'b1;
endmodule // wsps_pin_model

// ### wsps_pkg.sv
// Constants and types shared by the wake and sleep power sequencer
package wsps_pkg;
  // Register byte offsets on the APB slave
  localparam logic [7:0] OFF_POWER_STATE_CONTROL_STATUS = 8'h00;
  localparam logic [7:0] OFF_WAKE_CONTROL_STATUS = 8'h04;
  localparam logic [7:0] OFF_CLOCKRUN_CONTROL_STATUS = 8'h08;
  localparam logic [7:0] OFF_COMMAND_REGISTER = 8'h0c;
  localparam logic [7:0] OFF_RECEIVE_DESCRIPTOR_POINTER = 8'h10;
  localparam logic [7:0] OFF_CONFIG_RESTORE = 8'h14;
  localparam logic [7:0] OFF_SEQ_STATUS = 8'h18;
  // Field positions in the power state control/status word
  localparam int WAKE_STATUS_BIT = 15;
  localparam int WAKE_ENABLE_BIT = 8;
  localparam int POWER_STATE_LSB = 0;
  // Field positions in the command word
  localparam int RX_ENABLE_BIT = 2;
  localparam int RX_DISABLE_BIT = 3;
  // Field positions in the configuration restore word
  localparam int CFG_BASE_BIT = 0;
  localparam int CFG_MASTER_BIT = 1;
  // Width of the wake event vector
  localparam int WAKE_EVENTS = 8;
  // Reset values
  localparam logic [1:0] POWER_STATE_RESET = 2'h0;
  localparam logic [WAKE_EVENTS-1:0] WAKE_CONFIG_RESET = 8'h00;
  localparam logic [31:0] DESC_PTR_RESET = 32'h0000_0000;
  // Power states
  typedef enum logic [1:0] {
    WSPS_D0 = 2'b00,
    WSPS_D1 = 2'b01,
    WSPS_D2 = 2'b10,
    WSPS_D3HOT = 2'b11
  } wsps_pstate_t;
  // Receive path sequencing states
  typedef enum logic [1:0] {
    WSPS_RX_IDLE = 2'b00,
    WSPS_RX_FETCH = 2'b01,
    WSPS_RX_RUN = 2'b10
  } wsps_rx_state_t;
endpackage : wsps_pkg

// ### wsps_sync.sv
// Three-stage synchroniser with agreement filter for one pin input
`timescale 1ns/1ps
module wsps_sync
  import wsps_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Raw and filtered level
  input wire logic async_in,
  output logic sync_out
);
  logic [2:0] stage; // Stage 0 is read only by stage 1
  logic [2:0] next_stage;
  logic next_sync_out;

  // Shift and accept a change once the two later stages agree
  always_comb begin
    next_stage = {stage[1:0], async_in};
    next_sync_out = sync_out;
    if (stage[1] == stage[2]) begin
      next_sync_out = stage[2];
    end
  end

  // Register the stages
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stage <= 3'h0;
      sync_out <= 1'b0;
    end else begin
      stage <= next_stage;
      sync_out <= next_sync_out;
    end
  end
endmodule // wsps_sync

// ### wsps_top.sv
// Wake and sleep power sequencer with APB register slave
// Notes on behaviour
// R1 - Assert wake pin on enabled event
// R2 - Clearing wake enable releases wake pin
// R3 - Host clears power state and enable
// R4 - Reset on D3cold exit gives D0
// R5 - Operational registers locked until config restored
// R6 - Host reads wake status after wake
// R7 - Writing one clears pending wake status
// R8 - Host clears phy interrupt event
// R9 - Host clears all wake configuration bits
// R10 - Host restarts receiver in fixed order
// R11 - Held wake packet drained after enable
// R12 - Sleep mode detects no wake events
// R13 - Receive enable refetches descriptor pointer
// R14 - Sleep entry with no wake events
// R15 - System resets and powers off D3cold
// R16 - Host leaves sleep in fixed order
// R17 - Leaving D3hot resets config except wake
// R18 - D3hot keeps phy only when wake armed
// R19 - Wake status 15, enable 8, state 1:0
// R20 - Wake status holds until cleared
`timescale 1ns/1ps
module wsps_top
  import wsps_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Wake event inputs from filters and phy, one pin level each
  input wire logic [WAKE_EVENTS-1:0] wake_event_in,
  // Receive FIFO holds a packet from before the wake
  input wire logic rx_fifo_has_packet,
  // Open-drain wake request pin, active low
  input wire logic wake_request_n_pin_in,
  output logic wake_request_n_pin_out,
  output logic wake_request_n_pin_oe,
  // Power and receive path controls
  output logic phy_power_on,
  output logic rx_desc_fetch,
  output logic rx_dma_drain,
  output logic rx_running
);
  // Synchronised event levels
  logic [WAKE_EVENTS-1:0] event_sync;
  // Synchronised wake pin readback
  logic pin_sync;
  // Architectural state
  wsps_pstate_t power_state, next_power_state;
  logic wake_enable, next_wake_enable; // Survives D3hot exit
  logic wake_status, next_wake_status; // Sticky until written one
  logic [WAKE_EVENTS-1:0] wake_config, next_wake_config; // Enabled event types
  logic [WAKE_EVENTS-1:0] wake_cause, next_wake_cause; // Which event woke
  logic cfg_base, next_cfg_base; // Base addresses restored
  logic cfg_master, next_cfg_master; // Bus master enable restored
  logic locked, next_locked; // Operational registers blocked
  logic [31:0] desc_ptr, next_desc_ptr;
  wsps_rx_state_t rx_state, next_rx_state;
  logic drain_pending, next_drain_pending;
  logic [31:0] next_prdata;
  logic next_fetch, next_drain;

  // Each event line crosses into the core clock
  genvar gi;
  generate
    for (gi = 0; gi < WAKE_EVENTS; gi++) begin : g_sync
      wsps_sync u_sync (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .async_in(wake_event_in[gi]),
        .sync_out(event_sync[gi])
      );
    end
  endgenerate

  // Pin readback is a board level, so it crosses like an event line
  wsps_sync u_pin_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .async_in(wake_request_n_pin_in),
    .sync_out(pin_sync)
  );

  // Operational registers share one decode
  function automatic logic is_operational(input logic [7:0] a);
    is_operational = (a == OFF_COMMAND_REGISTER) || (a == OFF_RECEIVE_DESCRIPTOR_POINTER) ||
                     (a == OFF_CLOCKRUN_CONTROL_STATUS) || (a == OFF_WAKE_CONTROL_STATUS);
  endfunction

  // Known offsets of this slave
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = is_operational(a) || (a == OFF_POWER_STATE_CONTROL_STATUS) ||
                (a == OFF_CONFIG_RESTORE) || (a == OFF_SEQ_STATUS);
  endfunction

  // Wake logic is armed only in a low-power state with enable on
  logic wake_armed;
  logic access;
  logic wr;
  logic blocked;
  logic [WAKE_EVENTS-1:0] hits;
  assign access = psel && penable;
  assign wr = access && pwrite;
  // R5 - block while locked
  assign blocked = locked && is_operational(paddr);
  // R12 - sleep never arms
  assign wake_armed = wake_enable && (power_state != WSPS_D0) && (wake_config != WAKE_CONFIG_RESET);
  assign hits = event_sync & wake_config;
  // Zero wait state slave
  assign pready = psel && penable;
  assign pslverr = access && (!is_mapped(paddr) || blocked);

  // Next values of power, wake and config state
  always_comb begin
    next_power_state = power_state;
    next_wake_enable = wake_enable;
    next_wake_status = wake_status;
    next_wake_config = wake_config;
    next_wake_cause = wake_cause;
    next_cfg_base = cfg_base;
    next_cfg_master = cfg_master;
    next_locked = locked;
    next_desc_ptr = desc_ptr;
    if (wr && !pslverr) begin
      if (paddr == OFF_POWER_STATE_CONTROL_STATUS) begin
        // R19 - field positions
        next_power_state = wsps_pstate_t'(pwdata[POWER_STATE_LSB +: 2]);
        next_wake_enable = pwdata[WAKE_ENABLE_BIT];
        // R7 - write one clears
        if (pwdata[WAKE_STATUS_BIT]) begin
          next_wake_status = 1'b0;
          next_wake_cause = '0;
        end
        // R17 - leaving D3hot drops config
        if (power_state == WSPS_D3HOT && pwdata[POWER_STATE_LSB +: 2] != WSPS_D3HOT) begin
          next_cfg_base = 1'b0;
          next_cfg_master = 1'b0;
          next_locked = 1'b1;
        end
      end else if (paddr == OFF_CLOCKRUN_CONTROL_STATUS) begin
        // R7 - alternate clear path
        if (pwdata[WAKE_STATUS_BIT]) begin
          next_wake_status = 1'b0;
          next_wake_cause = '0;
        end
      end else if (paddr == OFF_WAKE_CONTROL_STATUS) begin
        next_wake_config = pwdata[WAKE_EVENTS-1:0];
      end else if (paddr == OFF_RECEIVE_DESCRIPTOR_POINTER) begin
        next_desc_ptr = pwdata;
      end else if (paddr == OFF_CONFIG_RESTORE) begin
        next_cfg_base = pwdata[CFG_BASE_BIT];
        next_cfg_master = pwdata[CFG_MASTER_BIT];
      end
    end
    // R5 - unlock once both restored
    if (next_cfg_base && next_cfg_master) begin
      next_locked = 1'b0;
    end
    // R1 - latch enabled events
    // R20 - set wins over clear
    if (wake_armed && (hits != '0)) begin
      next_wake_status = 1'b1;
      next_wake_cause = wake_cause | hits;
    end
  end

  // Register power, wake and config state
  always_ff @(posedge core_clk) begin
    // R4 - reset returns D0
    if (sys_rst) begin
      power_state <= WSPS_D0;
      wake_enable <= 1'b0;
      wake_status <= 1'b0;
      wake_config <= WAKE_CONFIG_RESET;
      wake_cause <= '0;
      cfg_base <= 1'b0;
      cfg_master <= 1'b0;
      locked <= 1'b1;
      desc_ptr <= DESC_PTR_RESET;
    end else begin
      power_state <= next_power_state;
      wake_enable <= next_wake_enable;
      wake_status <= next_wake_status;
      wake_config <= next_wake_config;
      wake_cause <= next_wake_cause;
      cfg_base <= next_cfg_base;
      cfg_master <= next_cfg_master;
      locked <= next_locked;
      desc_ptr <= next_desc_ptr;
    end
  end

  // Next values of the receive path sequencer
  always_comb begin
    next_rx_state = rx_state;
    next_drain_pending = drain_pending;
    next_fetch = 1'b0;
    next_drain = 1'b0;
    if (wake_status && rx_fifo_has_packet) begin
      next_drain_pending = 1'b1;
    end
    case (rx_state)
      WSPS_RX_IDLE: begin
        // R13 - enable refetches pointer
        if (wr && !pslverr && paddr == OFF_COMMAND_REGISTER && pwdata[RX_ENABLE_BIT]
            && !pwdata[RX_DISABLE_BIT]) begin
          next_rx_state = WSPS_RX_FETCH;
          next_fetch = 1'b1;
        end
      end
      WSPS_RX_FETCH: begin
        next_rx_state = WSPS_RX_RUN;
        // R11 - drain held packet
        if (drain_pending && desc_ptr != DESC_PTR_RESET && power_state == WSPS_D0) begin
          next_drain = 1'b1;
          next_drain_pending = 1'b0;
        end
      end
      WSPS_RX_RUN: begin
        if (wr && !pslverr && paddr == OFF_COMMAND_REGISTER && pwdata[RX_DISABLE_BIT]) begin
          next_rx_state = WSPS_RX_IDLE;
        end
      end
      default: begin
        next_rx_state = WSPS_RX_IDLE;
      end
    endcase
  end

  // Register receive sequencer and its pulses
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rx_state <= WSPS_RX_IDLE;
      drain_pending <= 1'b0;
      rx_desc_fetch <= 1'b0;
      rx_dma_drain <= 1'b0;
    end else begin
      rx_state <= next_rx_state;
      drain_pending <= next_drain_pending;
      rx_desc_fetch <= next_fetch;
      rx_dma_drain <= next_drain;
    end
  end

  // Read data mux, zeroed when the access is blocked
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (paddr == OFF_POWER_STATE_CONTROL_STATUS) begin
      next_prdata[POWER_STATE_LSB +: 2] = power_state;
      next_prdata[WAKE_ENABLE_BIT] = wake_enable;
      next_prdata[WAKE_STATUS_BIT] = wake_status;
    end else if (paddr == OFF_CLOCKRUN_CONTROL_STATUS) begin
      next_prdata[WAKE_STATUS_BIT] = wake_status;
    end else if (paddr == OFF_WAKE_CONTROL_STATUS) begin
      next_prdata = {8'h00, wake_cause, 8'h00, wake_config};
    end else if (paddr == OFF_RECEIVE_DESCRIPTOR_POINTER) begin
      next_prdata = desc_ptr;
    end else if (paddr == OFF_CONFIG_RESTORE) begin
      next_prdata[CFG_BASE_BIT] = cfg_base;
      next_prdata[CFG_MASTER_BIT] = cfg_master;
    end else if (paddr == OFF_SEQ_STATUS) begin
      next_prdata = {24'h000000, pin_sync, drain_pending, locked,
                     phy_power_on, 2'h0, rx_state};
    end
    if (blocked) begin
      next_prdata = 32'h0000_0000;
    end
  end

  // Read data is registered in setup so it stands during access
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= next_prdata;
    end
  end

  // R2 - pin follows enable and status
  assign wake_request_n_pin_oe = wake_status && wake_enable;
  assign wake_request_n_pin_out = 1'b0;
  // R18 - phy kept in D3hot only when armed
  assign phy_power_on = (power_state == WSPS_D0) || (power_state == WSPS_D1) ||
                        (power_state == WSPS_D2) || wake_armed;
  assign rx_running = (rx_state == WSPS_RX_RUN);
endmodule // wsps_top
